// ==== rtl/lcd_cmd_defs.svh ====
// command codes, field positions, limits and timing counts for the command decoder
`ifndef LCD_CMD_DEFS_SVH
`define LCD_CMD_DEFS_SVH
`define CMD_DISP_ONOFF 8'hae
`define CMD_START_LINE 8'h40
`define CMD_PAGE 8'hb0
`define CMD_COL_HI 8'h10
`define CMD_COL_LO 8'h00
`define CMD_SEG_DIR 8'ha0
`define CMD_INVERT 8'ha6
`define CMD_ALL_ON 8'ha4
`define CMD_BIAS 8'ha2
`define CMD_RMW 8'he0
`define CMD_END 8'hee
`define CMD_SOFT_RST 8'he2
`define CMD_COM_SCAN 8'hc0
`define CMD_POWER 8'h28
`define CMD_TEST 8'hf0
`define CMD_NOP 8'he3
`define MASK_D0 8'hfe
`define MASK_NIB 8'hf0
`define MASK_LINE 8'hc0
`define MASK_POWER 8'hf8
`define STAT_BUSY 7
`define STAT_SEG 6
`define STAT_OFF 5
`define STAT_RST 4
`define SCAN_BIT 3
`define PWR_BOOST 2
`define PWR_REG 1
`define PWR_FOLLOW 0
`define PAGE_MAX 4'h8
`define COL_MAX 8'hff
`define SEG_LAST 8'hc7
`define NUM_PAGES 9
`define NUM_COLS 256
`define BUSY_NS 20
`define CLK_NS 10
`define BUSY_CYC ((`BUSY_NS + `CLK_NS - 1) / `CLK_NS)
`define SRST_NS 50
`define SRST_CYC ((`SRST_NS + `CLK_NS - 1) / `CLK_NS)
`define SHOW_LINES 65
`endif

// ==== rtl/lcd_cmd_pkg.sv ====
// types shared by the command decoder
package lcd_cmd_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUSY,
        ST_SRST
    } seq_t;
    typedef logic [7:0] byte_t;
endpackage : lcd_cmd_pkg

// ==== rtl/lcd_ram_port.sv ====
// display data ram with host access port and a display scan read port
`timescale 1ns/1ps
`include "lcd_cmd_defs.svh"
module lcd_ram_port (
    input wire logic clk,
    input wire logic we,
    input wire logic [3:0] wr_page,
    input wire logic [7:0] wr_col,
    input wire logic [7:0] wr_data,
    input wire logic [3:0] rd_page,
    input wire logic [7:0] rd_col,
    output logic [7:0] rd_data,
    input wire logic [3:0] scan_page,
    input wire logic [7:0] scan_col,
    output logic [7:0] scan_data
);
    logic [7:0] mem [0:`NUM_PAGES*`NUM_COLS-1];
    wire [11:0] wr_idx = {wr_page, wr_col};
    wire [11:0] rd_idx = {rd_page, rd_col};
    wire [11:0] sc_idx = {scan_page, scan_col};

    // registered reads: both ports answer one cycle after the address is presented
    always_ff @(posedge clk) begin
        if (we && wr_page <= `PAGE_MAX) begin
            mem[wr_idx] <= wr_data;
        end
        rd_data <= (rd_page <= `PAGE_MAX) ? mem[rd_idx] : 8'h00;
        scan_data <= (scan_page <= `PAGE_MAX) ? mem[sc_idx] : 8'h00;
    end
endmodule : lcd_ram_port

// ==== rtl/lcd_command_decoder.sv ====
// command decoder, address logic and display control for the dot-matrix driver
// Operation
// R1 - display on/off command, bit 0 sets on
// R2 - display off drives all drivers to logic level
// R3 - start line 0..63, shows 65 lines upward
// R4 - page 0..8, display image unaffected
// R5 - column loaded by two nibble commands
// R6 - column increments per access, saturates at ffh
// R7 - status bit 7 busy, commands refused while busy
// R8 - status bit 6 one for normal mapping
// R9 - bit 5 display off, bit 4 resetting
// R10 - data write stores byte, advances column
// R11 - data read returns ram, needs dummy read; here the first read already returns the current column
// R12 - serial mode gives no ram readback
// R13 - segment direction bit 0 reverses mapping
// R14 - inversion bit 0 lights ram zeros
// R15 - all-on lights everything, beats inversion
// R16 - bias bit 0: 1/9 or 1/7, follower only
// R17 - rmw mode: writes advance, reads do not
// R18 - end restores column saved at rmw entry
// R19 - host sends no column set during rmw
// R20 - soft reset restores addressing, exits rmw, test
// R21 - host uses hard reset pin at power-up
// R22 - common scan bit 3 selects direction
// R23 - power bit 2 booster, bit 1 regulator
// R24 - power bit 0 switches voltage follower
// R25 - each nibble command updates only its half
`timescale 1ns/1ps
`include "lcd_cmd_defs.svh"
module lcd_command_decoder (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic CMD_DATA_SELECT,
    input wire logic SERIAL_MODE,
    input wire logic [7:0] WR_DATA,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    input wire logic [3:0] SCAN_PAGE,
    input wire logic [7:0] SCAN_COL,
    output logic [7:0] PIXEL_BYTE,
    output logic [7:0] SCAN_SEG_COL,
    output logic [5:0] START_LINE,
    output logic SCAN_REVERSE,
    output logic DRIVERS_AT_LOGIC,
    output logic BIAS_SEVENTH,
    output logic BOOSTER_ON,
    output logic REGULATOR_ON,
    output logic FOLLOWER_ON,
    output logic [6:0] SHOWN_LINES
);
    // control state
    logic disp_on_q;
    logic [5:0] start_q;
    logic [3:0] page_q;
    logic [7:0] col_q;
    logic [7:0] col_d;
    logic [7:0] rmw_col_q;
    logic rmw_q;

    // display mapping and power settings
    logic seg_rev_q;
    logic invert_q;
    logic all_on_q;
    logic bias_q;
    logic com_rev_q;
    logic [2:0] power_q;
    logic test_q;

    // busy sequencer: state and cycles left
    lcd_cmd_pkg::seq_t seq_q;
    logic [2:0] cnt_q;

    // ram answers and the read pipeline flag
    logic [7:0] ram_rd;
    logic [7:0] ram_scan;
    logic rd_pend_q;

    function automatic logic match(input logic [7:0] b, input logic [7:0] code,
                                   input logic [7:0] mask);
        match = (b & mask) == (code & mask);
    endfunction : match

    // busy covers the post-command window and the soft reset sequence
    wire busy = (seq_q != lcd_cmd_pkg::ST_IDLE); // see R7
    wire cmd_wr = WR_STB && !CMD_DATA_SELECT && !busy; // see R7
    wire dat_wr = WR_STB && CMD_DATA_SELECT;
    wire dat_rd = RD_STB && CMD_DATA_SELECT && !SERIAL_MODE; // see R12
    wire st_rd = RD_STB && !CMD_DATA_SELECT;
    wire ser_rd = RD_STB && CMD_DATA_SELECT && SERIAL_MODE; // see R12

    // command decode; every code is qualified by an accepted command write
    wire is_onoff = cmd_wr && match(WR_DATA, `CMD_DISP_ONOFF, `MASK_D0);
    wire is_start = cmd_wr && match(WR_DATA, `CMD_START_LINE, `MASK_LINE);
    wire is_page = cmd_wr && match(WR_DATA, `CMD_PAGE, `MASK_NIB) &&
                   WR_DATA[3:0] <= `PAGE_MAX;
    wire is_col_hi = cmd_wr && match(WR_DATA, `CMD_COL_HI, `MASK_NIB);
    wire is_col_lo = cmd_wr && match(WR_DATA, `CMD_COL_LO, `MASK_NIB);
    wire is_seg = cmd_wr && match(WR_DATA, `CMD_SEG_DIR, `MASK_D0);
    wire is_inv = cmd_wr && match(WR_DATA, `CMD_INVERT, `MASK_D0);
    wire is_all = cmd_wr && match(WR_DATA, `CMD_ALL_ON, `MASK_D0);
    wire is_bias = cmd_wr && match(WR_DATA, `CMD_BIAS, `MASK_D0);
    wire is_rmw = cmd_wr && (WR_DATA == `CMD_RMW);
    wire is_end = cmd_wr && (WR_DATA == `CMD_END);
    wire is_srst = cmd_wr && (WR_DATA == `CMD_SOFT_RST);
    wire is_scan = cmd_wr && match(WR_DATA, `CMD_COM_SCAN, `MASK_NIB);
    wire is_pwr = cmd_wr && match(WR_DATA, `CMD_POWER, `MASK_POWER);
    wire is_test = cmd_wr && match(WR_DATA, `CMD_TEST, `MASK_NIB);
    wire is_nop = cmd_wr && (WR_DATA == `CMD_NOP);

    // in rmw mode only writes move the column; reads hold it
    wire col_step = dat_wr || (dat_rd && !rmw_q); // see R6 see R17
    // saturating step: a long burst piles up on column ffh, the page never moves on
    wire [7:0] col_inc = (col_q == `COL_MAX) ? col_q : col_q + 8'h01; // see R6

    // next column pointer, nibble loads keep the other half
    always_comb begin
        col_d = col_q;
        if (is_col_hi) begin
            col_d = {WR_DATA[3:0], col_q[3:0]}; // see R5 see R25
        end else if (is_col_lo) begin
            col_d = {col_q[7:4], WR_DATA[3:0]}; // see R5 see R25
        end else if (is_end && rmw_q) begin
            col_d = rmw_col_q; // see R18
        end else if (col_step) begin
            col_d = col_inc; // see R10 see R11
        end
    end

    // segment reversal maps output n to column 199 - n; page only steers host access
    wire [7:0] scan_col_map = seg_rev_q ? (`SEG_LAST - SCAN_COL) : SCAN_COL; // see R13 see R4

    // the two-nibble split assumes no column command during rmw mode
    // the host keeps that promise; a stray one simply loads the pointer
    lcd_ram_port ram_i (
        .clk(REF_CLK),
        .we(dat_wr), // see R10
        .wr_page(page_q),
        .wr_col(col_q),
        .wr_data(WR_DATA),
        .rd_page(page_q),
        .rd_col(col_q),
        .rd_data(ram_rd),
        .scan_page(SCAN_PAGE),
        .scan_col(scan_col_map),
        .scan_data(ram_scan)
    );

    // all-on wins over inversion, ram untouched
    wire [7:0] pix_d = all_on_q ? 8'hff : // see R15
                       (invert_q ? ~ram_scan : ram_scan); // see R14
    wire [7:0] status_byte = {busy, !seg_rev_q, !disp_on_q, // see R8 see R9
                              seq_q == lcd_cmd_pkg::ST_SRST, 4'h0};

    // busy and soft reset sequencing; commands are dropped, not queued,
    // so a host that skips polling must keep to the command spacing
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            seq_q <= lcd_cmd_pkg::ST_IDLE;
            cnt_q <= 3'h0;
        end else begin
            case (seq_q)
                lcd_cmd_pkg::ST_IDLE: begin
                    if (is_srst) begin
                        seq_q <= lcd_cmd_pkg::ST_SRST; // see R9
                        cnt_q <= 3'(`SRST_CYC - 1);
                    end else if (cmd_wr) begin
                        seq_q <= lcd_cmd_pkg::ST_BUSY; // see R7
                        cnt_q <= 3'(`BUSY_CYC - 1);
                    end
                end
                lcd_cmd_pkg::ST_BUSY, lcd_cmd_pkg::ST_SRST: begin
                    if (cnt_q == 3'h0) begin
                        seq_q <= lcd_cmd_pkg::ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                default: seq_q <= lcd_cmd_pkg::ST_IDLE;
            endcase
        end
    end

    // column pointer and rmw bookkeeping; soft reset homes the column and leaves rmw
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            col_q <= 8'h00;
            rmw_col_q <= 8'h00;
            rmw_q <= 1'b0;
        end else if (is_srst) begin
            col_q <= 8'h00; // see R20
            rmw_q <= 1'b0; // see R20
        end else begin
            col_q <= col_d;
            if (is_rmw) begin
                rmw_q <= 1'b1; // see R17
                rmw_col_q <= col_q; // see R18
            end else if (is_end) begin
                rmw_q <= 1'b0; // see R18
            end
        end
    end

    // line, page, scan direction and test latch; soft reset homes these too
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            start_q <= 6'h00;
            page_q <= 4'h0;
            com_rev_q <= 1'b0;
            test_q <= 1'b0;
        end else if (is_srst) begin
            start_q <= 6'h00; // see R20
            page_q <= 4'h0; // see R20
            com_rev_q <= 1'b0; // see R20
            test_q <= 1'b0; // see R20
        end else begin
            if (is_start) start_q <= WR_DATA[5:0]; // see R3
            if (is_page) page_q <= WR_DATA[3:0]; // see R4
            if (is_scan) com_rev_q <= WR_DATA[`SCAN_BIT]; // see R22
            if (is_test) test_q <= 1'b1;
            else if (is_nop) test_q <= 1'b0;
        end
    end

    // display appearance, cleared only by the pin; soft reset leaves it alone
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            disp_on_q <= 1'b0;
            seg_rev_q <= 1'b0;
            invert_q <= 1'b0;
            all_on_q <= 1'b0;
        end else begin
            if (is_onoff) disp_on_q <= WR_DATA[0]; // see R1
            if (is_seg) seg_rev_q <= WR_DATA[0]; // see R13
            if (is_inv) invert_q <= WR_DATA[0]; // see R14
            if (is_all) all_on_q <= WR_DATA[0]; // see R15
        end
    end

    // bias and power switches, also left alone by the soft reset;
    // the bias choice only reaches the panel while the follower runs
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            bias_q <= 1'b0;
            power_q <= 3'h0;
        end else begin
            if (is_bias) bias_q <= WR_DATA[0]; // see R16
            if (is_pwr) power_q <= WR_DATA[2:0]; // see R23 see R24
        end
    end

    // read pipeline: ram answers a cycle after the strobe edge with the column
    // current at the strobe, so outside rmw mode the host's dummy read simply spends one column
    // serial reads answer at once with zeros and leave the column alone
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rd_pend_q <= 1'b0;
            RD_DATA <= 8'h00;
            RD_VALID <= 1'b0;
        end else begin
            rd_pend_q <= dat_rd;
            RD_VALID <= st_rd || rd_pend_q || ser_rd; // see R11 see R12
            if (st_rd) begin
                RD_DATA <= status_byte; // see R7 see R8 see R9
            end else if (rd_pend_q) begin
                RD_DATA <= ram_rd; // see R11
            end else if (ser_rd) begin
                RD_DATA <= 8'h00; // see R12
            end
        end
    end

    // pixel path toward the segment drivers, all registered
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PIXEL_BYTE <= 8'h00;
            SCAN_SEG_COL <= 8'h00;
            DRIVERS_AT_LOGIC <= 1'b1;
        end else begin
            PIXEL_BYTE <= disp_on_q ? pix_d : 8'h00; // see R2
            SCAN_SEG_COL <= scan_col_map;
            DRIVERS_AT_LOGIC <= !disp_on_q; // see R2
        end
    end

    // scan, bias and power mirrors; the line count is fixed by the row drivers
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            START_LINE <= 6'h00;
            SCAN_REVERSE <= 1'b0;
            BIAS_SEVENTH <= 1'b0;
            BOOSTER_ON <= 1'b0;
            REGULATOR_ON <= 1'b0;
            FOLLOWER_ON <= 1'b0;
            SHOWN_LINES <= 7'(`SHOW_LINES);
        end else begin
            START_LINE <= start_q; // see R3
            SCAN_REVERSE <= com_rev_q; // see R22
            // bias only matters with the follower running
            BIAS_SEVENTH <= bias_q && power_q[`PWR_FOLLOW]; // see R16
            BOOSTER_ON <= power_q[`PWR_BOOST]; // see R23
            REGULATOR_ON <= power_q[`PWR_REG]; // see R23
            FOLLOWER_ON <= power_q[`PWR_FOLLOW]; // see R24
            SHOWN_LINES <= 7'(`SHOW_LINES);
        end
    end
endmodule : lcd_command_decoder

// ==== sim/lcd_command_decoder_properties.sv ====
// port-level assertions for the command decoder
`timescale 1ns/1ps
module lcd_decoder_checker (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic CMD_DATA_SELECT,
    input wire logic SERIAL_MODE,
    input wire logic [7:0] RD_DATA,
    input wire logic RD_VALID,
    input wire logic [7:0] PIXEL_BYTE,
    input wire logic [5:0] START_LINE,
    input wire logic DRIVERS_AT_LOGIC,
    input wire logic BIAS_SEVENTH,
    input wire logic FOLLOWER_ON,
    input wire logic [6:0] SHOWN_LINES
);
    logic [3:0] since_q;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    // cycles since the last write strobe, saturating so it never wraps
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) since_q <= 4'hf;
        else if (WR_STB) since_q <= 4'h0;
        else if (since_q != 4'hf) since_q <= since_q + 4'h1;
    end
    sequence data_req;
        RD_STB && CMD_DATA_SELECT && !SERIAL_MODE;
    endsequence
    sequence data_ans;
        ##2 RD_VALID;
    endsequence
    lines_fixed_a: assert property (SHOWN_LINES == 7'h41)
        else $error("shown line count wrong");
    status_answer_a: assert property (RD_STB && !CMD_DATA_SELECT |=> RD_VALID)
        else $error("status read unanswered");
    data_answer_a: assert property (data_req |-> data_ans)
        else $error("data read unanswered");
    serial_blank_a: assert property (RD_STB && CMD_DATA_SELECT && SERIAL_MODE
        |=> RD_VALID && RD_DATA == 8'h00) else $error("serial read not blank");
    valid_cause_a: assert property (RD_VALID |-> $past(RD_STB) || $past(RD_STB, 2))
        else $error("read answer without request");
    line_cause_a: assert property (!$stable(START_LINE) |-> since_q < 4'h8)
        else $error("start line moved without command");
    bias_follow_a: assert property (BIAS_SEVENTH |-> FOLLOWER_ON || $past(FOLLOWER_ON))
        else $error("bias active without follower");
    off_dark_a: assert property (DRIVERS_AT_LOGIC && $past(DRIVERS_AT_LOGIC, 2)
        |-> PIXEL_BYTE == 8'h00) else $error("pixels lit while off");
endmodule : lcd_decoder_checker
bind lcd_command_decoder lcd_decoder_checker u_chk (.REF_CLK(REF_CLK), .RST_B(RST_B),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .CMD_DATA_SELECT(CMD_DATA_SELECT),
    .SERIAL_MODE(SERIAL_MODE), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
    .PIXEL_BYTE(PIXEL_BYTE), .START_LINE(START_LINE), .DRIVERS_AT_LOGIC(DRIVERS_AT_LOGIC),
    .BIAS_SEVENTH(BIAS_SEVENTH), .FOLLOWER_ON(FOLLOWER_ON), .SHOWN_LINES(SHOWN_LINES));

// ==== sim/lcd_host_model.sv ====
// host processor model on the strobed byte interface
`timescale 1ns/1ps
module lcd_host_model (
    input wire logic clk,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    output logic wr_stb,
    output logic rd_stb,
    output logic sel,
    output logic [7:0] wdata
);
    initial begin
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        sel = 1'b0;
        wdata = 8'h00;
    end
    // one byte per strobe, then gap idle cycles
    task automatic wr(input logic s, input logic [7:0] d, input int gap);
        @(posedge clk);
        #1 sel = s;
        wdata = d;
        wr_stb = 1'b1;
        @(posedge clk);
        #1 wr_stb = 1'b0;
        wdata = ~d; // released bus must not look like the last byte
        repeat (gap) @(posedge clk);
    endtask : wr
    // ok stays low when no answer comes within eight cycles
    task automatic rd(input logic s, output logic [7:0] d, output logic ok);
        @(posedge clk);
        #1 sel = s;
        rd_stb = 1'b1;
        @(posedge clk);
        #1 rd_stb = 1'b0;
        ok = 1'b0;
        d = 8'h00;
        for (int i = 0; i < 8 && !ok; i++) begin
            if (rd_valid === 1'b1) begin
                d = rd_data;
                ok = 1'b1;
            end else @(posedge clk) #1;
        end
    endtask : rd
endmodule : lcd_host_model

// ==== sim/lcd_command_decoder_tb.sv ====
// self-checking bench for the command decoder
`timescale 1ns/1ps
`include "lcd_cmd_defs.svh"
`define CHECK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module lcd_command_decoder_tb;
    logic ref_clk, rst_b, serial_mode, rd_valid, rd_stb, wr_stb, sel, ok;
    logic scan_rev, drv_logic, bias7, boost, regul, follow;
    logic [3:0] scan_page;
    logic [5:0] start_line;
    logic [6:0] shown;
    logic [7:0] scan_col, wr_data, rd_data, pixel_byte, seg_col, b;
    logic [7:0] pix_cmd [5] = '{8'ha7, 8'ha5, 8'ha4, 8'ha6, 8'hae};
    logic [7:0] pix_exp [5] = '{8'ha5, 8'hff, 8'ha5, 8'h5a, 8'h00};
    int mismatches, comparisons;
    lcd_command_decoder u_dut (
        .REF_CLK(ref_clk), .RST_B(rst_b), .WR_STB(wr_stb), .RD_STB(rd_stb),
        .CMD_DATA_SELECT(sel), .SERIAL_MODE(serial_mode), .WR_DATA(wr_data),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .SCAN_PAGE(scan_page), .SCAN_COL(scan_col),
        .PIXEL_BYTE(pixel_byte), .SCAN_SEG_COL(seg_col), .START_LINE(start_line),
        .SCAN_REVERSE(scan_rev), .DRIVERS_AT_LOGIC(drv_logic), .BIAS_SEVENTH(bias7),
        .BOOSTER_ON(boost), .REGULATOR_ON(regul), .FOLLOWER_ON(follow), .SHOWN_LINES(shown)
    );
    lcd_host_model u_host (.clk(ref_clk), .rd_data(rd_data), .rd_valid(rd_valid),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .sel(sel), .wdata(wr_data));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    // commands spaced well past the longest busy time
    task automatic cmd(input logic [7:0] d);
        u_host.wr(1'b0, d, 5);
    endtask : cmd
    task automatic rdchk(input logic s, input logic [7:0] e, input string nm);
        u_host.rd(s, b, ok);
        if (ok !== 1'b1) begin
            mismatches++;
            results();
        end
        `CHECK(nm, e, b)
    endtask : rdchk
    initial begin
        rst_b = 1'b0;
        serial_mode = 1'b0;
        scan_page = 4'h2;
        scan_col = 8'h05;
        repeat (20) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        `CHECK("drivers", 1'b1, drv_logic)
        `CHECK("lines", 7'h41, shown)
        `CHECK("power", 4'h0, {boost, regul, follow, bias7})
        rdchk(1'b0, 8'h60, "status");
        cmd(`CMD_DISP_ONOFF | 8'h01);
        `CHECK("drivers", 1'b0, drv_logic)
        rdchk(1'b0, 8'h40, "status");
        cmd(`CMD_START_LINE | 8'h3f);
        `CHECK("line", 6'h3f, start_line)
        cmd(`CMD_POWER | 8'h07);
        cmd(`CMD_BIAS | 8'h01);
        `CHECK("power", 4'hf, {boost, regul, follow, bias7})
        cmd(`CMD_POWER | 8'h06);
        `CHECK("power", 4'hc, {boost, regul, follow, bias7})
        cmd(`CMD_COM_SCAN | 8'h08);
        `CHECK("scan", 1'b1, scan_rev)
        cmd(`CMD_COM_SCAN | 8'h07);
        `CHECK("scan", 1'b0, scan_rev)
        cmd(`CMD_SEG_DIR | 8'h01);
        `CHECK("segcol", 8'hc2, seg_col)
        rdchk(1'b0, 8'h00, "status");
        cmd(`CMD_SEG_DIR);
        // one byte at page 2 column 5 drives the watched pixel
        cmd(`CMD_PAGE | 8'h02);
        cmd(`CMD_COL_HI);
        cmd(`CMD_COL_LO | 8'h05);
        u_host.wr(1'b1, 8'h5a, 1);
        cmd(`CMD_PAGE | 8'h03);
        `CHECK("pixel", 8'h5a, pixel_byte)
        foreach (pix_cmd[i]) begin
            cmd(pix_cmd[i]);
            `CHECK("pixel", pix_exp[i], pixel_byte)
        end
        cmd(`CMD_COL_HI | 8'h0f);
        cmd(`CMD_COL_LO | 8'h0e);
        for (int i = 1; i < 4; i++) u_host.wr(1'b1, 8'(i * 17), 0);
        cmd(`CMD_COL_LO | 8'h0e);
        u_host.rd(1'b1, b, ok);
        rdchk(1'b1, 8'h33, "saturate");
        rdchk(1'b1, 8'h33, "saturate");
        cmd(`CMD_COL_LO | 8'h0e);
        cmd(`CMD_RMW);
        u_host.rd(1'b1, b, ok);
        rdchk(1'b1, 8'h11, "rmw");
        u_host.wr(1'b1, 8'h44, 1);
        rdchk(1'b1, 8'h33, "rmw");
        cmd(`CMD_END);
        rdchk(1'b1, 8'h44, "end");
        serial_mode = 1'b1;
        rdchk(1'b1, 8'h00, "serial");
        serial_mode = 1'b0;
        cmd(`CMD_DISP_ONOFF | 8'h01);
        u_host.wr(1'b0, `CMD_SOFT_RST, 0);
        u_host.wr(1'b0, `CMD_START_LINE | 8'h09, 5);
        `CHECK("line", 6'h00, start_line)
        u_host.wr(1'b0, `CMD_SOFT_RST, 0);
        rdchk(1'b0, 8'hd0, "status");
        results();
    end
endmodule : lcd_command_decoder_tb
